// *** sucgp_pkg.sv ***
// Constants for the serial unit clock gate and shared prescaler
package sucgp_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [21:0] GATE_IDX = 22'h0f_00f0;
  localparam logic [21:0] PRESCALE_IDX = 22'h0f_0126;
  localparam logic [21:0] PRESCALE_LOW_IDX = 22'h0f_0130;
  localparam logic [21:0] GATE_BIT_IDX = 22'h0f_0131;
  localparam logic [23:0] GATE_ADDR = {GATE_IDX, 2'b00};
  localparam logic [23:0] PRESCALE_ADDR = {PRESCALE_IDX, 2'b00};
  localparam logic [23:0] PRESCALE_LOW_ADDR = {PRESCALE_LOW_IDX, 2'b00};
  localparam logic [23:0] GATE_BIT_ADDR = {GATE_BIT_IDX, 2'b00};
  // Field layout
  localparam int GATE_ENABLE_POS = 2;
  localparam logic [7:0] GATE_WRITE_MASK = 8'hf4;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam int CODE_W = 4;
  localparam int FIRST_CODE_LSB = 0;
  localparam int SECOND_CODE_LSB = 4;
  localparam int BIT_SEL_LSB = 0;
  localparam int BIT_VALUE_POS = 8;
  localparam int DIV_W = 15;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** sucgp_top.sv ***
// Serial unit clock gate and shared prescaler with AXI4-Lite registers

`timescale 1ns/1ps

module sucgp_top #(
  parameter int ADDR_W = 24,
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel side
  input wire logic [NUM_CH-1:0] channel_clock_choice,
  input wire logic [NUM_CH-1:0] channel_enabled_status,
  output logic [NUM_CH-1:0] channel_tick,
  // Unit clock control
  output logic serial_unit_clock_enable,
  output logic serial_unit_reset,
  output logic first_operation_clock,
  output logic second_operation_clock
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 24)
  begin : g_bad_addr
    $error("ADDR_W must be at least 24 to reach the register block");
  end
  if (NUM_CH < 1)
  begin : g_bad_ch
    $error("NUM_CH must be at least 1");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] gate_q;
  logic [7:0] gate_d;
  logic [7:0] prescale_q;
  logic [7:0] prescale_d;
  logic [sucgp_pkg::DIV_W-1:0] div_cnt_q;
  logic first_tick_q;
  logic second_tick_q;
  logic [NUM_CH-1:0] ch_tick_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire unit_on = gate_q[sucgp_pkg::GATE_ENABLE_POS];
  wire wr_go = ~awready_q & ~wready_q & ~bvalid_q;
  wire wr_gate = waddr_q == ADDR_W'(sucgp_pkg::GATE_ADDR);
  wire wr_prescale = waddr_q == ADDR_W'(sucgp_pkg::PRESCALE_ADDR);
  wire wr_low = waddr_q == ADDR_W'(sucgp_pkg::PRESCALE_LOW_ADDR);
  wire wr_bit = waddr_q == ADDR_W'(sucgp_pkg::GATE_BIT_ADDR);
  wire wr_hit = wr_gate | wr_prescale | wr_low | wr_bit;
  wire [2:0] bit_sel = wdata_q[sucgp_pkg::BIT_SEL_LSB +: 3];
  wire bit_val = wdata_q[sucgp_pkg::BIT_VALUE_POS];
  wire [7:0] bit_onehot = 8'h01 << bit_sel;
  wire [7:0] gate_bit_val = bit_val ? (gate_q | bit_onehot) : (gate_q & ~bit_onehot);
  function automatic logic [7:0] s_wmask(input logic en, input logic [7:0] nv,
                                         input logic [7:0] ov);
    s_wmask = en ? nv : ov;
  endfunction

  // Bits 3, 1 and 0 are kept at zero whatever software writes
  wire [7:0] gate_byte_val = s_wmask(wstrb_q[0], wdata_q[7:0], gate_q);

  always_comb
  begin
    gate_d = gate_q;
    if (wr_go && wr_gate)
      gate_d = gate_byte_val & sucgp_pkg::GATE_WRITE_MASK;
    else if (wr_go && wr_bit)
      gate_d = gate_bit_val & sucgp_pkg::GATE_WRITE_MASK;
  end

  // High byte of the prescale register is not stored and reads zero
  always_comb
  begin
    prescale_d = prescale_q;
    if (!unit_on)
      prescale_d = sucgp_pkg::PRESCALE_RESET;
    else if (wr_go && (wr_prescale || wr_low) && wstrb_q[0])
      prescale_d = wdata_q[7:0];
  end

  // ----------------------------------------------------------------
  // Register file and AXI write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate_q <= sucgp_pkg::GATE_RESET;
      prescale_q <= sucgp_pkg::PRESCALE_RESET;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= sucgp_pkg::RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      gate_q <= gate_d;
      prescale_q <= prescale_d;
      if (awready_q && s_axi_awvalid)
      begin
        awready_q <= 1'b0;
        waddr_q <= s_axi_awaddr;
      end
      if (wready_q && s_axi_wvalid)
      begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? sucgp_pkg::RESP_OKAY : sucgp_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  wire rd_gate = s_axi_araddr == ADDR_W'(sucgp_pkg::GATE_ADDR);
  wire rd_prescale = s_axi_araddr == ADDR_W'(sucgp_pkg::PRESCALE_ADDR);
  wire rd_low = s_axi_araddr == ADDR_W'(sucgp_pkg::PRESCALE_LOW_ADDR);
  wire rd_bit = s_axi_araddr == ADDR_W'(sucgp_pkg::GATE_BIT_ADDR);
  wire rd_hit = rd_gate | rd_prescale | rd_low | rd_bit;
  wire [31:0] rd_val = (rd_gate || rd_bit) ? {24'h00_0000, gate_q}
                     : (rd_prescale || rd_low) ? {24'h00_0000, prescale_q}
                     : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= sucgp_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else if (arready_q && s_axi_arvalid)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? sucgp_pkg::RESP_OKAY : sucgp_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  // One counter serves both clocks, so their ticks stay phase aligned
  wire [3:0] first_code = prescale_q[sucgp_pkg::FIRST_CODE_LSB +: sucgp_pkg::CODE_W];
  wire [3:0] second_code = prescale_q[sucgp_pkg::SECOND_CODE_LSB +: sucgp_pkg::CODE_W];
  wire [15:0] first_full = (16'h0001 << first_code) - 16'h0001;
  wire [15:0] second_full = (16'h0001 << second_code) - 16'h0001;
  wire [sucgp_pkg::DIV_W-1:0] first_mask = first_full[sucgp_pkg::DIV_W-1:0];
  wire [sucgp_pkg::DIV_W-1:0] second_mask = second_full[sucgp_pkg::DIV_W-1:0];
  wire first_hit = unit_on && ((div_cnt_q & first_mask) == first_mask);
  wire second_hit = unit_on && ((div_cnt_q & second_mask) == second_mask);

  // Gate low stops the counter and holds it at zero, as the unit reset
  // Port and filter control lives outside this block and is never cleared here
  always_ff @(posedge clk)
  begin
    if (rst || !unit_on)
    begin
      div_cnt_q <= '0;
      first_tick_q <= 1'b0;
      second_tick_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 15'h0001;
      first_tick_q <= first_hit;
      second_tick_q <= second_hit;
    end
  end

  genvar gi;
  for (gi = 0; gi < NUM_CH; gi++)
  begin : g_ch
    always_ff @(posedge clk)
    begin
      if (rst)
        ch_tick_q[gi] <= 1'b0;
      else
        ch_tick_q[gi] <= channel_clock_choice[gi] ? second_hit : first_hit;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic unit_rst_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      unit_rst_q <= 1'b1;
    else
      unit_rst_q <= ~gate_d[sucgp_pkg::GATE_ENABLE_POS];
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign channel_tick = ch_tick_q;
  assign serial_unit_clock_enable = unit_on;
  assign serial_unit_reset = unit_rst_q;
  assign first_operation_clock = first_tick_q;
  assign second_operation_clock = second_tick_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Tick must come from code 2 itself, not from the code it replaced
  sequence s_second_div4;
    second_tick_q && unit_on && second_code == 4'h2 && $past(second_code) == 4'h2
      ##1 (unit_on && second_code == 4'h2) [*3];
  endsequence

  AST_RESET_VALUES: assert property (@(posedge clk) rst |=> gate_q == 8'h00 && prescale_q == 8'h00)
    else $error("registers not zero after reset");
  AST_DISABLED_CLEARS: assert property (@(posedge clk) disable iff (rst) !unit_on |=> prescale_q == 8'h00)
    else $error("prescale not cleared while unit disabled");
  AST_DISABLED_NO_TICK: assert property (@(posedge clk) disable iff (rst)
      !unit_on |-> serial_unit_reset ##1 (!first_tick_q && !second_tick_q))
    else $error("tick or no reset while unit disabled");
  AST_CODE0_EVERY: assert property (@(posedge clk) disable iff (rst)
      unit_on && first_code == 4'h0 |=> first_tick_q)
    else $error("code zero did not tick every cycle");
  AST_DIV4_PERIOD: assert property (@(posedge clk) disable iff (rst) s_second_div4 |=> second_tick_q)
    else $error("divide by four tick missing");
  AST_DIV4_GAP: assert property (@(posedge clk) disable iff (rst)
      second_tick_q && second_code == 4'h2 && $past(second_code) == 4'h2 && unit_on
      |=> !second_tick_q)
    else $error("divide by four ticked twice in a row");
  AST_PRESCALE_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_go && (wr_prescale || wr_low) && wstrb_q[0] && unit_on
      |=> prescale_q == $past(wdata_q[7:0]))
    else $error("prescale write not taken");
  AST_BIT_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_go && wr_bit && bit_sel == 3'h2 |=> unit_on == $past(bit_val))
    else $error("single bit write to gate failed");
  AST_CHANNEL_PICK: assert property (@(posedge clk) disable iff (rst)
      ##1 ch_tick_q[0] == ($past(channel_clock_choice[0]) ? second_tick_q : first_tick_q))
    else $error("channel tick does not follow its clock choice");
  AST_B_HOLD: assert property (@(posedge clk) disable iff (rst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  COV_ENABLE: cover property (@(posedge clk) disable iff (rst) !unit_on ##1 unit_on);
  COV_SLOWEST: cover property (@(posedge clk) disable iff (rst) second_tick_q && second_code == 4'hf);
  COV_LOW_WRITE: cover property (@(posedge clk) disable iff (rst) wr_go && wr_low && unit_on);
  COV_UNMAPPED: cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rresp != 2'b00);

endmodule // sucgp_top

// *** tb_top.sv ***
// Self-checking testbench for the serial unit clock gate and shared prescaler
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h got %h", nm, e, g); end end

module tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] s_axi_awaddr = 24'h00_0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [23:0] s_axi_araddr = 24'h00_0000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [1:0] channel_clock_choice = 2'h2;
  logic [1:0] channel_enabled_status = 2'h0;
  logic [1:0] channel_tick;
  logic serial_unit_clock_enable;
  logic serial_unit_reset;
  logic first_operation_clock;
  logic second_operation_clock;
  int miscompares = 0;
  int checked = 0;
  int gap[4] = '{0, 0, 0, 0};
  int cnt[4] = '{0, 0, 0, 0};
  int npls[4] = '{0, 0, 0, 0};
  wire logic [3:0] pls = {channel_tick, second_operation_clock, first_operation_clock};

  sucgp_top u_sucgp_top (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .channel_clock_choice(channel_clock_choice),
    .channel_enabled_status(channel_enabled_status), .channel_tick(channel_tick),
    .serial_unit_clock_enable(serial_unit_clock_enable), .serial_unit_reset(serial_unit_reset),
    .first_operation_clock(first_operation_clock), .second_operation_clock(second_operation_clock)
  );

  // ---------------------------------------------------------------
  // Clock, pulse gap monitor and watchdog
  // ---------------------------------------------------------------
  // System clock never changes source in a run, so no stop is owed
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Gap is cycles between pulses; a stuck-high pulse shows as gap 1
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (pls[i] === 1'b1)
      begin
        gap[i] = cnt[i] + 1;
        cnt[i] = 0;
        npls[i]++;
      end
      else
        cnt[i]++;
    end
  end

  initial
  begin
    // Prescale sweep needs about 88k cycles at worst
    repeat (98000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
    @(negedge clk);
  endtask

  task automatic axi_read(input logic [23:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] code;
    int s;
    int n;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("enable", 1'b0, serial_unit_clock_enable)
    `CHK("unit_reset", 1'b1, serial_unit_reset)
    axi_read(sucgp_pkg::GATE_ADDR, 32'h0000_0000, 2'h0);
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0000, 2'h0);
    axi_write(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0021, 4'h3, 2'h0);
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0000, 2'h0);
    $display("test reset_and_locked done");

    axi_write(sucgp_pkg::GATE_ADDR, 32'h0000_00f4, 4'h1, 2'h0);
    axi_read(sucgp_pkg::GATE_ADDR, 32'h0000_00f4, 2'h0);
    `CHK("enable", 1'b1, serial_unit_clock_enable)
    `CHK("unit_reset", 1'b0, serial_unit_reset)
    axi_write(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0021, 4'h3, 2'h0);
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0021, 2'h0);
    axi_write(sucgp_pkg::PRESCALE_LOW_ADDR, 32'h0000_0053, 4'h1, 2'h0);
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0053, 2'h0);
    axi_write(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0077, 4'h0, 2'h0);
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0053, 2'h0);
    axi_write(24'h00_0010, 32'h0000_0001, 4'h1, 2'h2);
    axi_read(24'h00_0010, 32'h0000_0000, 2'h2);
    $display("test register_access done");

    // Even codes on the first clock, odd codes on the second
    for (int k = 0; k < 16; k += 2)
    begin
      code = {4'(k + 1), 4'(k)};
      axi_write(sucgp_pkg::PRESCALE_ADDR, {24'h00_0000, code}, 4'h1, 2'h0);
      s = npls[1];
      n = 0;
      while (npls[1] < s + 2 && n < 70000)
      begin
        @(negedge clk);
        n++;
      end
      `CHK("first_gap", 32'(1 << k), 32'(gap[0]))
      `CHK("second_gap", 32'(1 << (k + 1)), 32'(gap[1]))
      `CHK("tick0_gap", 32'(1 << k), 32'(gap[2]))
      `CHK("tick1_gap", 32'(1 << (k + 1)), 32'(gap[3]))
    end
    // Divide by four on the second clock, undivided on the first
    axi_write(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0020, 4'h1, 2'h0);
    repeat (20) @(negedge clk);
    `CHK("second_gap", 32'h0000_0004, 32'(gap[1]))
    `CHK("first_gap", 32'h0000_0001, 32'(gap[0]))
    $display("test prescale_codes done");

    axi_write(sucgp_pkg::GATE_BIT_ADDR, 32'h0000_0002, 4'h3, 2'h0);
    axi_read(sucgp_pkg::GATE_ADDR, 32'h0000_00f0, 2'h0);
    `CHK("enable", 1'b0, serial_unit_clock_enable)
    `CHK("unit_reset", 1'b1, serial_unit_reset)
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0000, 2'h0);
    axi_write(sucgp_pkg::PRESCALE_LOW_ADDR, 32'h0000_0035, 4'h1, 2'h0);
    s = npls[0];
    repeat (40) @(negedge clk);
    `CHK("stopped", 32'(s), 32'(npls[0]))
    axi_read(sucgp_pkg::PRESCALE_ADDR, 32'h0000_0000, 2'h0);
    axi_write(sucgp_pkg::GATE_BIT_ADDR, 32'h0000_0102, 4'h3, 2'h0);
    axi_read(sucgp_pkg::GATE_ADDR, 32'h0000_00f4, 2'h0);
    `CHK("enable", 1'b1, serial_unit_clock_enable)
    $display("test bit_gate done");
    complete_run();
  end
endmodule // tb_top
